// *** hdl/load_switch_pkg.sv ***
// ==========================================================
// Shared constants and types of the remote load switch
package load_switch_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 8;                   // 125 MHz reference clock
  localparam int unsigned BIT_TIME_NS    = 3330000;             // 3.33 ms per telegram bit
  localparam int unsigned BIT_CYCLES     = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_TIME_NS     = 1000000;             // Millisecond time base
  localparam int unsigned MS_CYCLES      = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_MIN    = 3;                   // Reception loss window
  localparam int unsigned TIMEOUT_MS     = TIMEOUT_MIN * 60000;
  localparam int unsigned WARN_TIME_MS   = 60000;               // Warning before shutoff
  localparam int unsigned WARN_BEEPS     = 10;
  localparam int unsigned WARN_PERIOD_MS = WARN_TIME_MS / WARN_BEEPS;
  localparam int unsigned BEEP_ON_MS     = 100;                 // Length of one beep
  localparam int unsigned BEEP_GAP_MS    = 100;                 // Silence after one beep

  // ==========================================================
  // Qualification
  localparam logic [1:0] QUAL_COUNT = 2'h3;                     // Identical decisions to act
  localparam logic [1:0] QUAL_ONE   = 2'h1;                     // Fast shutdown count

  // ==========================================================
  // Telegram layout, bit 0 first on the line
  localparam int unsigned FRAME_BITS = 18;
  localparam int unsigned SOC_LSB    = 0;
  localparam int unsigned GEN_LSB    = 8;
  localparam int unsigned EXC_LSB    = 12;
  localparam int unsigned NIGHT_BIT  = 16;
  localparam logic [7:0]  SOC_MAX    = 8'h64;                   // 100 percent
  localparam logic [7:0]  SOC_TOP    = 8'h5a;                   // 90 percent, top band
  localparam logic [7:0]  BAND_DIV   = 8'h0a;
  localparam logic [3:0]  ID_MAX     = 4'h9;
  localparam logic [3:0]  EXC_ON     = 4'h0;
  localparam logic [3:0]  EXC_OFF    = 4'h9;
  localparam logic [3:0]  SEL_MAX    = 4'h9;

  // ==========================================================
  // Jumper block, one-hot
  localparam int unsigned JMP_W      = 5;
  localparam logic [4:0]  JMP_SOC    = 5'h01;
  localparam logic [4:0]  JMP_GEN    = 5'h02;
  localparam logic [4:0]  JMP_SOLAR  = 5'h04;
  localparam logic [4:0]  JMP_EXCESS = 5'h08;
  localparam logic [4:0]  JMP_NIGHT  = 5'h10;

  typedef enum logic [2:0] {MODE_NONE, MODE_SOC, MODE_GEN, MODE_SOLAR, MODE_EXCESS, MODE_NIGHT} mode_t;
  typedef enum logic [1:0] {WANT_HOLD, WANT_ON, WANT_OFF} want_t;

endpackage : load_switch_pkg

// *** hdl/remote_load_switch.sv ***
`timescale 1ns/10ps
module remote_load_switch
  import load_switch_pkg::*;
#(
  parameter int unsigned BIT_CYC     = BIT_CYCLES,     // Cycles per telegram bit
  parameter int unsigned MS_CYC      = MS_CYCLES,      // Cycles per millisecond tick
  parameter int unsigned TIMEOUT_TMS = TIMEOUT_MS,     // Silence before failsafe, ms
  parameter int unsigned WARN_PER_MS = WARN_PERIOD_MS  // Spacing of warning beeps, ms
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ook_i,                        // Demodulated carrier envelope
  input  wire logic [3:0] first_threshold_selector_i,   // Rotary, 0 to 9
  input  wire logic [3:0] second_threshold_selector_i,  // Rotary, 0 to 9
  input  wire logic [4:0] mode_jumper_i,                // One-hot jumper block
  input  wire logic       button_i,                     // S terminals closed
  output logic            load_en_o,                    // Load switch on
  output logic            buzzer_o                      // Buzzer drive
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [16:0] ms_div;      // Millisecond prescaler
    logic [3:0]  sel1_q;      // Last seen first selector
    logic [3:0]  sel2_q;      // Last seen second selector
    logic [1:0]  sel_init;    // Sync stages filled; all ones once baselined
    logic [4:0]  beep_pend;   // Step beeps still to play
    logic [7:0]  beep_ms;     // Step beep timer
    logic [17:0] silence_ms;  // Time since last good telegram
    logic        timed_out;   // Reception lost
    want_t       last_want;   // Last telegram decision
    logic [1:0]  qual_cnt;    // Identical decisions in a row
    mode_t       mode_q;      // Mode of previous cycle
    logic        decided;     // Data-driven load state
    logic        warn;        // Shutoff warning running
    logic [3:0]  warn_beeps;  // Warning beeps done
    logic [12:0] warn_ms;     // Position within one warning beep
    logic        load_out;
    logic        buzz_out;
  } top_t;

  top_t s;
  top_t next_s;

  logic        line;          // Synchronised carrier
  logic [7:0]  sel_sync;      // Both selectors, synchronised
  logic [5:0]  misc_sync;     // Jumpers and button, synchronised
  logic [3:0]  sel1;
  logic [3:0]  sel2;
  logic [4:0]  jumper;
  logic        button;
  logic        rx_valid;
  logic        rx_err;
  logic [7:0]  rx_soc;
  logic [3:0]  rx_gen;
  logic [3:0]  rx_exc;
  logic        rx_night;

  // ==========================================================
  // Pin synchronisers
  sync_bits #(.W(1)) u_sync_line (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       (ook_i),
    .q_o       (line)
  );

  sync_bits #(.W(8)) u_sync_sel (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({second_threshold_selector_i, first_threshold_selector_i}),
    .q_o       (sel_sync)
  );

  sync_bits #(.W(6)) u_sync_misc (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({button_i, mode_jumper_i}),
    .q_o       (misc_sync)
  );

  assign sel1   = sel_sync[3:0];
  assign sel2   = sel_sync[7:4];
  assign jumper = misc_sync[JMP_W-1:0];
  assign button = misc_sync[JMP_W];

  // ==========================================================
  // Telegram receiver
  telegram_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .line_i    (line),
    .valid_o   (rx_valid),
    .err_o     (rx_err),
    .soc_o     (rx_soc),
    .gen_o     (rx_gen),
    .exc_o     (rx_exc),
    .night_o   (rx_night)
  );

  // ==========================================================
  // Decision logic
  mode_t      mode;
  logic       tick;
  logic [3:0] band;
  want_t      want;
  logic [3:0] d1;
  logic [3:0] d2;
  logic [5:0] pend_sum;
  logic [1:0] cnt_new;
  logic [1:0] need;

  always_comb begin
    case (jumper)
      JMP_SOC:    mode = MODE_SOC;
      JMP_GEN:    mode = MODE_GEN;
      JMP_SOLAR:  mode = MODE_SOLAR;
      JMP_EXCESS: mode = MODE_EXCESS;
      JMP_NIGHT:  mode = MODE_NIGHT;
      default:    mode = MODE_NONE;
    endcase
  end

  assign tick = (s.ms_div == '0);

  assign band = (rx_soc >= SOC_TOP) ? SEL_MAX : 4'(rx_soc / BAND_DIV);

  always_comb begin
    want = WANT_HOLD;
    case (mode)
      MODE_SOC: begin
        // On at or above second, off at or below first
        if (band >= sel2) begin
          want = WANT_ON;
        end else if (band <= sel1) begin
          want = WANT_OFF;
        end
      end
      MODE_GEN: begin
        // Generator runs below second, stops at or above first
        if (band < sel2) begin
          want = WANT_ON;
        end else if (band >= sel1) begin
          want = WANT_OFF;
        end
      end
      MODE_SOLAR: begin
        // Arrays below the sent identifier stay on
        want = (!rx_night && rx_gen > sel1) ? WANT_ON : WANT_OFF;
      end
      MODE_EXCESS: begin
        // Position 9 keeps the consumer on
        want = (sel1 == SEL_MAX || rx_exc == EXC_ON) ? WANT_ON : WANT_OFF;
      end
      MODE_NIGHT: begin
        want = rx_night ? WANT_ON : WANT_OFF;
      end
      default: begin
        want = WANT_HOLD;
      end
    endcase
  end

  assign cnt_new = (want == s.last_want) ? ((s.qual_cnt == QUAL_COUNT) ? QUAL_COUNT : s.qual_cnt + 2'h1) : QUAL_ONE;
  assign need = ((mode == MODE_SOLAR || mode == MODE_EXCESS) && want == WANT_OFF) ? QUAL_ONE : QUAL_COUNT;

  assign d1       = (sel1 > s.sel1_q) ? sel1 - s.sel1_q : s.sel1_q - sel1;
  assign d2       = (sel2 > s.sel2_q) ? sel2 - s.sel2_q : s.sel2_q - sel2;
  assign pend_sum = 6'(s.beep_pend) + (&s.sel_init ? 6'(d1) + 6'(d2) : 6'h00);

  // Next state of the controller
  always_comb begin
    next_s        = s;
    next_s.ms_div = tick ? 17'(MS_CYC - 1) : s.ms_div - 17'h00001;
    next_s.mode_q = mode;
    next_s.sel1_q = sel1;
    next_s.sel2_q = sel2;
    // Synchronisers show zeros after reset; baseline only real pin levels
    next_s.sel_init = (&s.sel_init) ? s.sel_init : s.sel_init + 2'h1;

    // Step beeps; new steps queue up behind the running one
    next_s.beep_pend = (pend_sum > 6'h1f) ? 5'h1f : pend_sum[4:0];
    if (tick && s.beep_ms != '0) begin
      next_s.beep_ms = s.beep_ms - 8'h01;
    end else if (s.beep_ms == '0 && pend_sum != '0) begin
      next_s.beep_ms   = 8'(BEEP_ON_MS + BEEP_GAP_MS);
      next_s.beep_pend = (pend_sum > 6'h20) ? 5'h1f : 5'(pend_sum - 6'h01);
    end

    if (rx_valid) begin
      next_s.silence_ms = '0;
      next_s.timed_out  = 1'b0;
    end else if (tick && !s.timed_out) begin
      next_s.silence_ms = s.silence_ms + 18'h00001;
      if (s.silence_ms == 18'(TIMEOUT_TMS - 1)) begin
        next_s.timed_out = 1'b1;
        next_s.qual_cnt  = '0;
        if (mode != MODE_SOC) begin
          next_s.decided = 1'b0;
          next_s.warn    = 1'b0;
        end
      end
    end

    if (rx_err) begin
      next_s.qual_cnt = '0;
    end

    if (s.warn && tick) begin
      next_s.warn_ms = s.warn_ms + 13'h0001;
      if (s.warn_ms == 13'(WARN_PER_MS - 1)) begin
        next_s.warn_ms    = '0;
        next_s.warn_beeps = s.warn_beeps + 4'h1;
        // load drops after the tenth beep
        if (s.warn_beeps == 4'(WARN_BEEPS - 1)) begin
          next_s.warn    = 1'b0;
          next_s.decided = 1'b0;
        end
      end
    end

    if (rx_valid) begin
      next_s.last_want = want;
      next_s.qual_cnt  = cnt_new;
      if (cnt_new >= need) begin
        if (want == WANT_ON) begin
          next_s.decided = 1'b1;
          next_s.warn    = 1'b0;
        end else if (want == WANT_OFF) begin
          if (mode == MODE_SOC) begin
            // warn first when load is on
            if (s.decided && !s.warn) begin
              next_s.warn       = 1'b1;
              next_s.warn_beeps = '0;
              next_s.warn_ms    = '0;
            end
          end else begin
            next_s.decided = 1'b0;
          end
        end
      end
    end

    // mode change or bad jumpers start over
    if (mode != s.mode_q || mode == MODE_NONE) begin
      next_s.decided  = 1'b0;
      next_s.warn     = 1'b0;
      next_s.qual_cnt = '0;
    end

    next_s.load_out = (mode != MODE_NONE) && (s.decided || button);

    if (&s.sel_init && sel1 == sel2) begin
      next_s.buzz_out = 1'b1;
    end else if (s.warn && mode == MODE_SOC) begin
      next_s.buzz_out = (s.warn_ms < 13'(BEEP_ON_MS));
    end else begin
      next_s.buzz_out = (s.beep_ms > 8'(BEEP_GAP_MS));
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign load_en_o = s.load_out;
  assign buzzer_o  = s.buzz_out;
endmodule : remote_load_switch

// *** hdl/sync_bits.sv ***
`timescale 1ns/10ps
// ==========================================================
// Two-stage synchroniser for a group of pin levels
module sync_bits #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;    // First stage, read only by second
    logic [W-1:0] stable;  // Second stage
  } sync_t;

  sync_t s;
  sync_t next_s;

  // Shift pins through both stages
  always_comb begin
    next_s.meta   = d_i;
    next_s.stable = s.meta;
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.stable;
endmodule : sync_bits

// *** hdl/telegram_rx.sv ***
`timescale 1ns/10ps
// ==========================================================
// Bit timing and telegram assembly from the demodulated carrier
module telegram_rx
  import load_switch_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       line_i,    // Synchronised carrier present
  output logic            valid_o,   // One-cycle pulse, fields valid
  output logic            err_o,     // One-cycle pulse, corrupt frame
  output logic      [7:0] soc_o,
  output logic      [3:0] gen_o,
  output logic      [3:0] exc_o,
  output logic            night_o
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  typedef struct packed {
    rx_state_t              state;
    logic [19:0]            tmr;     // Bit timer
    logic [4:0]             idx;     // Data bit index
    logic [FRAME_BITS-1:0]  shreg;   // Frame shifter
    logic                   valid;
    logic                   err;
    logic [7:0]             soc;
    logic [3:0]             gen;
    logic [3:0]             exc;
    logic                   night;
  } rx_t;

  rx_t s;
  rx_t next_s;
  logic plausible;                   // Field ranges are sane

  // Range check of the assembled frame
  assign plausible = (s.shreg[SOC_LSB+:8] <= SOC_MAX) && (s.shreg[GEN_LSB+:4] <= ID_MAX) &&
                     ((s.shreg[EXC_LSB+:4] == EXC_ON) || (s.shreg[EXC_LSB+:4] == EXC_OFF));

  // Receiver sequence
  always_comb begin
    next_s       = s;
    next_s.valid = 1'b0;
    next_s.err   = 1'b0;
    case (s.state)
      RX_IDLE: begin
        if (line_i) begin
          next_s.state = RX_START;
          next_s.tmr   = 20'(BIT_CYC / 2);
        end
      end
      RX_START: begin
        if (s.tmr == '0) begin
          // Glitch shorter than half a bit is dropped
          next_s.state = line_i ? RX_DATA : RX_IDLE;
          next_s.tmr   = 20'(BIT_CYC - 1);
          next_s.idx   = '0;
        end else begin
          next_s.tmr = s.tmr - 20'h00001;
        end
      end
      RX_DATA: begin
        // one sample per 3.33 ms bit
        if (s.tmr == '0) begin
          next_s.shreg = {line_i, s.shreg[FRAME_BITS-1:1]};
          next_s.tmr   = 20'(BIT_CYC - 1);
          next_s.idx   = s.idx + 5'h01;
          if (s.idx == 5'(FRAME_BITS - 1)) begin
            next_s.state = RX_STOP;
          end
        end else begin
          next_s.tmr = s.tmr - 20'h00001;
        end
      end
      RX_STOP: begin
        if (s.tmr == '0) begin
          next_s.state = RX_IDLE;
          if (!line_i && !(^s.shreg) && plausible) begin
            next_s.valid = 1'b1;
            next_s.soc   = s.shreg[SOC_LSB+:8];
            next_s.gen   = s.shreg[GEN_LSB+:4];
            next_s.exc   = s.shreg[EXC_LSB+:4];
            next_s.night = s.shreg[NIGHT_BIT];
          end else begin
            next_s.err = 1'b1;
          end
        end else begin
          next_s.tmr = s.tmr - 20'h00001;
        end
      end
      default: begin
        next_s.state = RX_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign valid_o = s.valid;
  assign err_o   = s.err;
  assign soc_o   = s.soc;
  assign gen_o   = s.gen;
  assign exc_o   = s.exc;
  assign night_o = s.night;
endmodule : telegram_rx

// *** sim/load_switch_sva.sv ***
`timescale 1ns/10ps
// ==========================================================
// Port-level checks of the remote load switch
module load_switch_sva
  import load_switch_pkg::*;
#(
  parameter int unsigned BIT_CYC = BIT_CYCLES,  // Cycles per telegram bit
  parameter int unsigned MS_CYC  = MS_CYCLES    // Cycles per millisecond
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ook_i,
  input  wire logic [3:0] first_threshold_selector_i,
  input  wire logic [3:0] second_threshold_selector_i,
  input  wire logic [4:0] mode_jumper_i,
  input  wire logic       button_i,
  input  wire logic       load_en_o,
  input  wire logic       buzzer_o
);
  // ==========================================================
  // Helper counters
  localparam int HOLD_CYC  = 40 * BIT_CYC;   // Shorter than three telegrams
  localparam int QUIET_CYC = 8;              // Selector sync and register delay
  localparam int LOW_CYC   = 102 * MS_CYC;   // Longer than any gap inside a step beep train
  localparam int BEEP_WAIT = 8;              // Sync delay plus register, no tick wait
  logic       jmp_ok;     // Exactly one jumper
  logic       btn_seen;   // Button pressed since reset
  logic       ld_q;       // Load one cycle back
  logic       bz_q;       // Buzzer one cycle back
  logic [7:0] sel_q;      // Selectors one cycle back
  int         since_rst;  // Cycles since reset, saturating
  int         quiet;      // Cycles with selectors unmoved
  int         btn_idle;   // Cycles with button released
  int         bz_low;     // Cycles with buzzer silent, saturating
  int         beeps;      // Beeps since load came on
  assign jmp_ok = $onehot(mode_jumper_i);
  // Counters reset with the design so no stale history leaks across a reset
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      since_rst <= 0;
      quiet     <= 0;
      btn_idle  <= 0;
      bz_low    <= 0;
      beeps     <= 0;
      btn_seen  <= 1'b0;
      ld_q      <= 1'b0;
      bz_q      <= 1'b0;
      sel_q     <= 8'h00;
    end else begin
      ld_q     <= load_en_o;
      bz_q     <= buzzer_o;
      sel_q    <= {first_threshold_selector_i, second_threshold_selector_i};
      btn_seen <= btn_seen | button_i;
      if (since_rst < HOLD_CYC) since_rst <= since_rst + 1;
      if (button_i) btn_idle <= 0;
      else if (btn_idle < 16) btn_idle <= btn_idle + 1;
      if (buzzer_o) bz_low <= 0;
      else if (bz_low < LOW_CYC) bz_low <= bz_low + 1;
      if ({first_threshold_selector_i, second_threshold_selector_i} != sel_q) quiet <= 0;
      else if (quiet < QUIET_CYC) quiet <= quiet + 1;
      if (load_en_o && !ld_q) beeps <= 0;
      else if (buzzer_o && !bz_q) beeps <= beeps + 1;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // Sequences
  sequence s_bad_jumper;
    (!jmp_ok)[*5];
  endsequence
  sequence s_equal_sel;
    (first_threshold_selector_i == second_threshold_selector_i)[*8];
  endsequence
  sequence s_button_held;
    (jmp_ok && button_i && $stable(mode_jumper_i))[*5];
  endsequence
  // ==========================================================
  // Assertions
  // invalid jumper off
  AST_BAD_JUMPER_OFF: assert property (s_bad_jumper |-> !load_en_o)
    else $error("load on with invalid jumper setting");
  AST_EQUAL_SEL_TONE: assert property (s_equal_sel |-> buzzer_o)
    else $error("no steady tone with equal selectors");
  AST_BUTTON_ON: assert property (s_button_held |-> load_en_o)
    else $error("held button did not enable load");
  AST_POWERUP_OFF: assert property ((since_rst < HOLD_CYC && !btn_seen) |-> !load_en_o)
    else $error("load on too soon after reset");
  AST_NO_WARN_OTHER: assert property ((quiet >= QUIET_CYC && bz_low >= LOW_CYC
      && first_threshold_selector_i != second_threshold_selector_i
      && mode_jumper_i != JMP_SOC && $past(mode_jumper_i, 4) != JMP_SOC) |-> !buzzer_o)
    else $error("buzzer sounds outside charge manager");
  AST_STEP_BEEP: assert property (($changed(first_threshold_selector_i) || $changed(second_threshold_selector_i))
      && bz_low >= LOW_CYC && mode_jumper_i != JMP_SOC
      && $past(mode_jumper_i, 4) != JMP_SOC |-> ##[1:BEEP_WAIT] buzzer_o)
    else $error("selector step without beep");
  AST_WARN_BEEPS: assert property (($fell(load_en_o) && mode_jumper_i == JMP_SOC
      && $past(mode_jumper_i, 4) == JMP_SOC && btn_idle >= 16) |-> beeps >= 10)
    else $error("charge manager dropped load before ten beeps");
  AST_MODE_CLEAR: assert property (($changed(mode_jumper_i) && jmp_ok && $onehot($past(mode_jumper_i))
      && btn_idle >= 16) |-> ##[1:6] !load_en_o)
    else $error("load kept across mode change");
endmodule : load_switch_sva

bind remote_load_switch load_switch_sva #(.BIT_CYC(BIT_CYC), .MS_CYC(MS_CYC)) sva_u (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ook_i(ook_i),
  .first_threshold_selector_i(first_threshold_selector_i),
  .second_threshold_selector_i(second_threshold_selector_i),
  .mode_jumper_i(mode_jumper_i), .button_i(button_i), .load_en_o(load_en_o), .buzzer_o(buzzer_o)
);

// *** sim/tb.sv ***
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench of the remote load switch
module tb
  import load_switch_pkg::*;
;
  localparam int unsigned BITC = 16;   // Short bit time
  localparam int unsigned MSC  = 8;    // Short millisecond
  localparam int unsigned TOMS = 200;  // Silence window, ms
  localparam int unsigned WPMS = 200;  // Warning beep spacing, ms
  logic        ref_clk_i, resetn_i, ook, start, corrupt, button, load_en, buzzer, busy, exp_load;
  logic [3:0]  sel_a, sel_b;
  logic [4:0]  jumper;
  logic [16:0] payload;
  logic [7:0]  soc;
  logic [7:0]  corner [3] = '{8'h64, 8'h1d, 8'h3b};  // Top band, on, hold
  int          n_mismatch, samples_checked, seed, rises;

  remote_load_switch #(.BIT_CYC(BITC), .MS_CYC(MSC), .TIMEOUT_TMS(TOMS), .WARN_PER_MS(WPMS)) dut_u (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ook_i(ook),
    .first_threshold_selector_i(sel_a), .second_threshold_selector_i(sel_b),
    .mode_jumper_i(jumper), .button_i(button), .load_en_o(load_en), .buzzer_o(buzzer));
  telegram_tx_model #(.BIT_CYC(BITC)) tx_u (
    .ref_clk_i(ref_clk_i), .start_i(start), .payload_i(payload), .corrupt_i(corrupt),
    .ook_o(ook), .busy_o(busy));

  // ==========================================================
  // Helpers
  task automatic check(input logic seen, input logic exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  task automatic give_up();
    n_mismatch++;
    conclude();
  endtask : give_up
  // Sends n telegrams, each waited out under a bound
  task automatic sendn(input int n, input logic [7:0] s, input logic [3:0] g, input logic [3:0] e,
                       input logic nt, input logic bad);
    int k;
    for (int j = 0; j < n; j++) begin
      payload = {nt, e, g, s};
      corrupt = bad;
      start   = 1'b1;
      k = 0;
      while (busy !== 1'b1 && k < 50) begin
        @(negedge ref_clk_i);
        k++;
      end
      start = 1'b0;
      // Sender never answered
      if (busy !== 1'b1) give_up();
      k = 0;
      while (busy !== 1'b0 && k < 1000) begin
        @(negedge ref_clk_i);
        k++;
      end
      // Telegram never ended
      if (busy !== 1'b0) give_up();
      repeat (8) @(negedge ref_clk_i);
    end
  endtask : sendn
  // Counts buzzer rises; a beep already on at entry counts too
  task automatic watch(input int cyc, input logic until_off);
    logic prev;
    rises = 0;
    prev  = 1'b0;
    for (int c = 0; c < cyc; c++) begin
      @(negedge ref_clk_i);
      if (buzzer === 1'b1 && prev === 1'b0) rises++;
      prev = buzzer;
      if (until_off && load_en === 1'b0) return;
    end
    if (until_off) give_up();
  endtask : watch
  // Generator manager: on below second band, off from first band up
  function automatic logic exp_gen(input logic [7:0] s, input logic now);
    logic [3:0] band;
    band = (s >= SOC_TOP) ? 4'h9 : 4'(s / BAND_DIV);
    if (band < sel_b) return 1'b1;
    if (band >= sel_a) return 1'b0;
    return now;
  endfunction : exp_gen

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================
  // Main sequence, inputs move on falling edges
  initial begin
    resetn_i = 1'b0;
    start    = 1'b0;
    corrupt  = 1'b0;
    payload  = '0;
    button   = 1'b0;
    jumper   = JMP_EXCESS;
    sel_a    = 4'h0;
    sel_b    = 4'h9;
    seed     = 3;
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (12) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    check(load_en, 1'b0);
    sel_a = 4'h6;
    watch(6 * 200 * MSC + 800, 1'b0);
    check(rises == 6, 1'b1);
    // excess: three to switch on, one to switch off
    sendn(2, 8'h32, 4'h0, EXC_ON, 1'b0, 1'b0);
    check(load_en, 1'b0);
    sendn(1, 8'h32, 4'h0, EXC_ON, 1'b0, 1'b0);
    check(load_en, 1'b1);
    sendn(1, 8'h32, 4'h0, EXC_OFF, 1'b0, 1'b0);
    check(load_en, 1'b0);
    button = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    check(load_en, 1'b1);
    jumper = JMP_EXCESS | JMP_NIGHT;
    repeat (8) @(negedge ref_clk_i);
    check(load_en, 1'b0);
    jumper = 5'h00;
    repeat (8) @(negedge ref_clk_i);
    check(load_en, 1'b0);
    button = 1'b0;
    jumper = JMP_EXCESS;
    watch(2000, 1'b0);
    check(rises == 0, 1'b1);
    sendn(2, 8'h32, 4'h0, EXC_ON, 1'b0, 1'b0);
    sendn(1, 8'h32, 4'h0, EXC_ON, 1'b0, 1'b1);
    sendn(1, 8'h32, 4'h0, EXC_ON, 1'b0, 1'b0);
    check(load_en, 1'b0);
    sendn(2, 8'h32, 4'h0, EXC_ON, 1'b0, 1'b0);
    check(load_en, 1'b1);
    jumper = JMP_NIGHT;
    sendn(3, 8'h32, 4'h0, EXC_OFF, 1'b1, 1'b0);
    check(load_en, 1'b1);
    jumper = JMP_SOLAR;
    repeat (8) @(negedge ref_clk_i);
    check(load_en, 1'b0);
    sendn(3, 8'h32, 4'h7, EXC_OFF, 1'b0, 1'b0);
    check(load_en, 1'b1);
    repeat (TOMS * MSC + 200) @(negedge ref_clk_i);
    check(load_en, 1'b0);
    // generator manager, corners then random charge
    jumper   = JMP_GEN;
    sel_b    = 4'h3;
    exp_load = 1'b0;
    for (int i = 0; i < 8; i++) begin
      soc = (i < 3) ? corner[i] : 8'($unsigned($random(seed)) % 101);
      sendn(3, soc, 4'($unsigned($random(seed)) % 10), EXC_OFF, 1'b0, 1'b0);
      exp_load = exp_gen(soc, exp_load);
      check(load_en, exp_load);
    end
    jumper = JMP_SOC;
    sel_a  = 4'h3;
    sel_b  = 4'h7;
    repeat (14000) @(negedge ref_clk_i);
    sendn(3, 8'h55, 4'h0, EXC_OFF, 1'b0, 1'b0);
    check(load_en, 1'b1);
    sendn(3, 8'h14, 4'h0, EXC_OFF, 1'b0, 1'b0);
    check(load_en, 1'b1);
    watch(12 * WPMS * MSC, 1'b1);
    check(rises == 10, 1'b1);
    jumper = JMP_NIGHT;
    repeat (500) @(negedge ref_clk_i);
    sel_b = 4'h3;
    for (int i = 0; i < 4; i++) begin
      repeat (300) @(negedge ref_clk_i);
      check(buzzer, 1'b1);
    end
    conclude();
  end
endmodule : tb

// *** sim/telegram_tx_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// Charge controller side: one telegram per request
module telegram_tx_model #(
  parameter int unsigned BIT_CYC = 16  // Cycles per bit
) (
  input  wire logic        ref_clk_i,
  input  wire logic        start_i,    // Request one telegram
  input  wire logic [16:0] payload_i,  // Night, excess, generator, charge
  input  wire logic        corrupt_i,  // Spoil the parity bit
  output logic             ook_o,      // Carrier envelope
  output logic             busy_o      // Telegram in flight
);
  logic [19:0] frame;  // Start, 18 bits, stop
  // silent until asked
  // ==========================================================
  // Sender; carrier off between telegrams, one process owns both outputs
  initial begin
    ook_o  = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      if (start_i) begin
        frame  = {1'b0, ^payload_i ^ corrupt_i, payload_i, 1'b1};
        busy_o <= 1'b1;
        for (int i = 0; i < 20; i++) begin
          ook_o <= frame[i];
          repeat (BIT_CYC) @(posedge ref_clk_i);
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : telegram_tx_model
